// ==== include/tsp_pkg.sv ====
/*
 * tsp_pkg: constants shared by the two-wire register port of the temperature sensor.
 * assumes a 100 MHz system clock and bus pins already synchronous to it.
 */
package tsp_pkg;
	localparam logic [1:0] SEL_TEMP = 2'h0;
	localparam logic [1:0] SEL_CONFIG = 2'h1;
	localparam logic [1:0] SEL_LOW = 2'h2;
	localparam logic [1:0] SEL_HIGH = 2'h3;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [15:0] TEMP_RESET = 16'h0000;
	localparam logic [15:0] CONFIG_RESET = 16'h2610;
	localparam logic [15:0] LOW_RESET = 16'h0000;
	localparam logic [15:0] HIGH_RESET = 16'h0000;
	// target addresses for strap low, high, tied to data; values arbitrary
	localparam logic [6:0] ADDR_STRAP_LOW = 7'h48;
	localparam logic [6:0] ADDR_STRAP_HIGH = 7'h49;
	localparam logic [6:0] ADDR_STRAP_DATA = 7'h4A;
	localparam int CLK_MHZ = 100;
	localparam int TIMEOUT_MIN_MS = 21;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MIN_MS * CLK_MHZ * 1000;
	localparam int POWER_UP_US = 1000;
	localparam int POWER_UP_CYCLES = POWER_UP_US * CLK_MHZ;
	localparam int TIMER_W = 32;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK, ST_SKIP} tsp_state_t;
endpackage : tsp_pkg

// ==== rtl/tsp_timer.sv ====
/*
 * tsp_timer: counter that raises done once run has stayed high for limit cycles.
 * assumes limit is at least one.
 */
`timescale 1ns/1ps
`default_nettype none
module tsp_timer (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic [tsp_pkg::TIMER_W-1:0] limit,
	output logic done
);
	import tsp_pkg::*;
	logic [TIMER_W-1:0] count_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= '0;
		end else if (!run) begin
			count_q <= '0;
		end else if (count_q != limit) begin
			count_q <= count_q + 1'b1;
		end
	end
	assign done = run && (count_q == limit);
endmodule : tsp_timer
`default_nettype wire

// ==== rtl/tsp_port.sv ====
/*
 * tsp_port: two-wire target port with select index and four 16-bit registers.
 * assumes scl and sda inputs already synchronous to clk; clk far faster than the bus.
 */
`timescale 1ns/1ps
`default_nettype none
module tsp_port #(
	parameter int TIMEOUT_LIMIT = tsp_pkg::TIMEOUT_CYCLES,
	parameter int POWER_UP_LIMIT = tsp_pkg::POWER_UP_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] address_strap_pin,
	input wire logic conv_valid,
	input wire logic [15:0] conv_result,
	output logic [15:0] operating_config,
	output logic [15:0] low_limit,
	output logic [15:0] high_limit,
	output logic [7:0] register_select_index,
	output logic in_transaction
);
	import tsp_pkg::*;

	// ==========================================================
	// bus conditions
	logic scl_q, sda_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end
	wire scl_rise = scl_in && !scl_q;
	wire scl_fall = !scl_in && scl_q;
	wire start_c = scl_in && scl_q && sda_q && !sda_in;
	wire stop_c = scl_in && scl_q && !sda_q && sda_in;

	// ==========================================================
	// timeout and power-up delay
	logic in_trans_q, timeout, pu_done, pu_done_q;
	tsp_timer u_timeout (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(in_trans_q && !scl_in),
		.limit(TIMER_W'(TIMEOUT_LIMIT)),
		.done(timeout)
	);
	tsp_timer u_power_up (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(!pu_done_q),
		.limit(TIMER_W'(POWER_UP_LIMIT)),
		.done(pu_done)
	);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pu_done_q <= 1'b0;
		end else if (pu_done) begin
			pu_done_q <= 1'b1;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			in_trans_q <= 1'b0;
		end else if (start_c) begin
			in_trans_q <= 1'b1;
		end else if (stop_c || timeout) begin
			in_trans_q <= 1'b0;
		end
	end
	assign in_transaction = in_trans_q;

	// ==========================================================
	// own address from the strap: 0 low, 1 high, 2 tied to data
	logic [6:0] own_addr;
	always_comb begin
		case (address_strap_pin)
			2'h1: own_addr = ADDR_STRAP_HIGH;
			2'h2: own_addr = ADDR_STRAP_DATA;
			default: own_addr = ADDR_STRAP_LOW;
		endcase
	end

	// ==========================================================
	// byte engine
	tsp_state_t state_q;
	logic [7:0] shift_q;
	logic [2:0] bit_q;
	logic rw_q, first_q, hi_q, drive_q, seen_q;
	logic [15:0] temp_q, cfg_q, low_q, high_q;
	logic [7:0] sel_q;
	logic [7:0] wbyte;
	logic [15:0] rd_word;
	assign wbyte = {shift_q[6:0], sda_in};
	always_comb begin
		case (sel_q[1:0])
			SEL_TEMP: rd_word = temp_q;
			SEL_CONFIG: rd_word = cfg_q;
			SEL_LOW: rd_word = low_q;
			SEL_HIGH: rd_word = high_q;
			default: rd_word = temp_q;
		endcase
	end

	// engine samples on rising scl and changes sda on falling scl, so any rate works while scl low time stays under the timeout
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			bit_q <= 3'h0;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			hi_q <= 1'b1;
			drive_q <= 1'b0;
			seen_q <= 1'b0;
		end else if (timeout || stop_c) begin
			state_q <= ST_IDLE;
			drive_q <= 1'b0;
		end else if (start_c) begin
			state_q <= ST_ADDR;
			bit_q <= 3'h0;
			drive_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_WRITE: begin
					if (scl_rise) begin
						shift_q <= wbyte;
						bit_q <= bit_q + 3'h1;
						seen_q <= 1'b1;
					end
					// the scl fall that closes a start has no bits behind it, so it is no byte end
					if (scl_fall && bit_q == 3'h0 && seen_q) begin
						if (state_q == ST_ADDR) begin
							if (shift_q[7:1] == own_addr) begin
								rw_q <= shift_q[0];
								first_q <= 1'b1;
								hi_q <= 1'b1;
								drive_q <= 1'b1;
								state_q <= ST_ACK;
							end else begin
								state_q <= ST_SKIP;
							end
						end else begin
							first_q <= 1'b0;
							if (!first_q) begin
								hi_q <= !hi_q;
							end
							drive_q <= 1'b1;
							state_q <= ST_ACK;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_q) begin
							shift_q <= hi_q ? rd_word[15:8] : rd_word[7:0];
							hi_q <= !hi_q;
							drive_q <= !(hi_q ? rd_word[15] : rd_word[7]);
							bit_q <= 3'h1;
							state_q <= ST_READ;
						end else begin
							drive_q <= 1'b0;
							bit_q <= 3'h0;
							state_q <= ST_WRITE;
						end
					end
				end
				ST_READ: begin
					if (scl_fall) begin
						if (bit_q == 3'h0) begin
							drive_q <= 1'b0;
							state_q <= ST_RACK;
						end else begin
							drive_q <= !shift_q[3'h7 - bit_q];
							bit_q <= bit_q + 3'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						state_q <= sda_in ? ST_SKIP : ST_ACK; // controller nack ends the read
					end
				end
				ST_SKIP, ST_IDLE: begin
					drive_q <= 1'b0;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = drive_q;

	// ==========================================================
	// register writes
	wire wr_done = (state_q == ST_WRITE) && scl_fall && bit_q == 3'h0;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_q <= SELECT_RESET;
		end else if (wr_done && first_q) begin
			sel_q <= shift_q;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_q <= CONFIG_RESET;
			low_q <= LOW_RESET;
			high_q <= HIGH_RESET;
		end else if (wr_done && !first_q) begin
			// temperature result ignores writes
			case (sel_q[1:0])
				SEL_CONFIG: begin
					if (hi_q) cfg_q[15:8] <= shift_q;
					else cfg_q[7:0] <= shift_q;
				end
				SEL_LOW: begin
					if (hi_q) low_q[15:8] <= shift_q;
					else low_q[7:0] <= shift_q;
				end
				SEL_HIGH: begin
					if (hi_q) high_q[15:8] <= shift_q;
					else high_q[7:0] <= shift_q;
				end
				default: ;
			endcase
		end
	end
	// result stays zero until the delay passes and a conversion lands
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			temp_q <= TEMP_RESET;
		end else if (pu_done_q && conv_valid) begin
			temp_q <= {conv_result[15:4], 4'h0};
		end
	end
	assign operating_config = cfg_q;
	assign low_limit = low_q;
	assign high_limit = high_q;
	assign register_select_index = sel_q;
endmodule : tsp_port
`default_nettype wire

// ==== bench/tsp_port_sva.sv ====
/* tsp_port_chk: pin assertions for the register port. assumes bind from the bench top. */
`timescale 1ns/1ps
`default_nettype none
// ====
// checker
module tsp_port_chk #(
	parameter int TIMEOUT_LIMIT = 200
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic [15:0] operating_config,
	input wire logic [15:0] low_limit,
	input wire logic [15:0] high_limit,
	input wire logic [7:0] register_select_index,
	input wire logic in_transaction
);
	import tsp_pkg::*;
	int low_q;
	// counts bus clock low time inside a transaction only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) low_q <= 0;
		else low_q <= (in_transaction && !scl_in) ? low_q + 1 : 0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_reset_vals:
	assert property ($fell(sys_rst) |-> register_select_index == SELECT_RESET
		&& operating_config == CONFIG_RESET && low_limit == LOW_RESET) else $error("bad reset");
	chk_timeout_bound:
	assert property (low_q <= TIMEOUT_LIMIT + 3) else $error("no timeout");
	chk_release_idle:
	assert property (!in_transaction |=> !sda_oe) else $error("sda held");
	chk_oe_scl_low:
	assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved");
	chk_index_stable:
	assert property (!in_transaction |=> $stable(register_select_index)) else $error("index");
	chk_regs_stable:
	assert property (!in_transaction |=> $stable(low_limit) && $stable(high_limit)
		&& $stable(operating_config)) else $error("regs moved");
	chk_start_seen:
	assert property (scl_in && $fell(sda_in) |-> ##[1:3] in_transaction) else $error("start");
	chk_stop_seen:
	assert property (scl_in && $rose(sda_in) |-> ##[1:3] !in_transaction) else $error("stop");
	cover property ($rose(sda_oe));
	cover property (low_q == TIMEOUT_LIMIT);
	cover property ($changed(register_select_index));
endmodule : tsp_port_chk
`default_nettype wire

// ==== bench/tsp_host.sv ====
/* tsp_host: two-wire bus controller model. assumes the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
// ====
// controller
module tsp_host (
	input wire logic clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic drv = 1'b1;
	// pull-up wins unless someone pulls low, so a released line reads high
	assign sda = drv & ~sda_oe;
	initial scl = 1'b1;
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic bit_io(input logic b, output logic r);
		drv = b;
		tick(4);
		scl = 1'b1;
		tick(4);
		r = sda;
		scl = 1'b0;
	endtask : bit_io
	task automatic start_c;
		drv = 1'b1;
		scl = 1'b1;
		tick(4);
		drv = 1'b0;
		tick(4);
		scl = 1'b0;
	endtask : start_c
	task automatic stop_c;
		drv = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		drv = 1'b1;
		tick(4);
	endtask : stop_c
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic k);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, k);
	endtask : byte_io
endmodule : tsp_host
`default_nettype wire

// ==== bench/tsp_port_tb_top.sv ====
/* tsp_port_tb_top: self-checking bench. assumes host model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tsp_port_tb_top;
	import tsp_pkg::*;
	typedef struct {logic [1:0] s; logic [15:0] w; logic [15:0] e;} tsp_row_t;
	tsp_row_t rows [4] = '{'{2'h1, 16'hA5C3, 16'hA5C3}, '{2'h2, 16'h8001, 16'h8001},
		'{2'h3, 16'h7FFE, 16'h7FFE}, '{2'h0, 16'hBEEF, 16'h1900}};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic scl, sda, sda_oe, in_transaction, k;
	logic conv_valid = 1'b0;
	logic [1:0] strap = 2'h0;
	logic [6:0] adr = ADDR_STRAP_LOW;
	logic [7:0] idx, q;
	logic [15:0] conv_result = 16'h0000;
	logic [15:0] cfg, lo_l, hi_l, got;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	tsp_host host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	// short limits keep the run brief
	tsp_port #(.TIMEOUT_LIMIT(200), .POWER_UP_LIMIT(20)) uut (.clk(clk), .sys_rst(sys_rst),
		.scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .address_strap_pin(strap),
		.conv_valid(conv_valid), .conv_result(conv_result), .operating_config(cfg),
		.low_limit(lo_l), .high_limit(hi_l), .register_select_index(idx),
		.in_transaction(in_transaction));
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		if (errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wb(input logic [7:0] d, input logic e);
		host.byte_io(d, 1'b1, q, k);
		chk({15'h0000, k}, {15'h0000, e});
	endtask : wb
	task automatic wreg(input logic [1:0] s, input logic [15:0] v);
		host.start_c();
		wb({adr, 1'b0}, 1'b0);
		wb({6'h00, s}, 1'b0);
		wb(v[15:8], 1'b0);
		wb(v[7:0], 1'b0);
		host.stop_c();
	endtask : wreg
	task automatic rreg(output logic [15:0] v);
		host.start_c();
		wb({adr, 1'b1}, 1'b0);
		host.byte_io(8'hFF, 1'b0, v[15:8], k);
		host.byte_io(8'hFF, 1'b1, v[7:0], k);
		host.stop_c();
	endtask : rreg
	task automatic pulse(input logic [15:0] v);
		conv_result = v;
		conv_valid = 1'b1;
		@(negedge clk);
		conv_valid = 1'b0;
	endtask : pulse
	initial begin
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		pulse(16'h7FF0);
		chk(cfg, CONFIG_RESET);
		chk({8'h00, idx} | lo_l | hi_l, 16'h0000);
		rreg(got);
		chk(got, TEMP_RESET);
		pulse(16'h190F);
		foreach (rows[i]) begin
			wreg(rows[i].s, rows[i].w);
			rreg(got);
			chk(got, rows[i].e);
			chk({8'h00, idx}, {14'h0000, rows[i].s});
		end
		chk(cfg ^ lo_l ^ hi_l, 16'hA5C3 ^ 16'h8001 ^ 16'h7FFE);
		for (int i = 0; i < 3; i++) begin
			strap = i[1:0];
			adr = (i == 0) ? ADDR_STRAP_LOW : (i == 1) ? ADDR_STRAP_HIGH : ADDR_STRAP_DATA;
			host.start_c();
			wb({adr, 1'b0}, 1'b0);
			host.stop_c();
			host.start_c();
			wb({adr ^ 7'h03, 1'b0}, 1'b1);
			host.stop_c();
		end
		// bus left stuck low while the device drives its acknowledge
		host.start_c();
		q = {adr, 1'b0};
		for (int i = 7; i >= 0; i--) host.bit_io(q[i], k);
		host.tick(2);
		chk({15'h0000, sda_oe}, 16'h0001);
		host.tick(250);
		chk({14'h0000, sda_oe, in_transaction}, 16'h0000);
		host.stop_c();
		rreg(got);
		chk(got, 16'h1900);
		give_verdict();
	end
endmodule : tsp_port_tb_top
bind tsp_port tsp_port_chk #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) chk_i (.clk(clk),
	.sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
	.operating_config(operating_config), .low_limit(low_limit), .high_limit(high_limit),
	.register_select_index(register_select_index), .in_transaction(in_transaction));
`default_nettype wire
